// >>> rtl/alu_ops_defines.vh
`ifndef ALU_OPS_DEFINES_VH
`define ALU_OPS_DEFINES_VH
`define OP_NONE 3'h0
`define OP_ROTATE_RIGHT 3'h1
`define OP_LITERAL_MINUS_ACC 3'h2
`define OP_FILE_MINUS_ACC 3'h3
`define OP_FILE_MINUS_ACC_BORROW 3'h4
`define OP_NIBBLE_EXCHANGE 3'h5
`define OP_SLEEP 3'h6
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`define ACC_RESET 8'h00
`define FLAG_RESET 1'b0
`define EXPIRY_RESET 1'b1
`define SLEEP_ENTERED_RESET 1'b1
`define FILE_ADDR_RESET 7'h00
`define FILE_DATA_RESET 8'h00
`define HALF_BORROW_TAP 4
`define CARRY_TAP 8
`define WATCHDOG_RESET 16'h0000
`define PRESCALER_RESET 8'h00
`define WATCHDOG_WIDTH 16
`define PRESCALER_WIDTH 8
`endif

// >>> rtl/alu_ops.v
`timescale 1ns/1ps
`include "alu_ops_defines.vh"
module alu_ops #(
  parameter WD_WIDTH = `WATCHDOG_WIDTH,
  parameter PS_WIDTH = `PRESCALER_WIDTH
) (
  input wire clk,
  input wire resetn,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire dest_sel,
  input wire [6:0] file_addr,
  input wire [7:0] file_data,
  input wire [7:0] literal,
  input wire wd_clear,
  output reg [7:0] acc_q,
  output reg carry_flag_q,
  output reg half_borrow_flag_q,
  output reg zero_flag_q,
  output reg expiry_flag_q,
  output reg sleep_entered_flag_q,
  output reg file_we_q,
  output reg [6:0] file_waddr_q,
  output reg [7:0] file_wdata_q,
  output reg [WD_WIDTH-1:0] watchdog_counter_q,
  output reg [PS_WIDTH-1:0] prescaler_q
);

  // Decoded operation strobes; the idle and reserved codes decode to none of them.
  reg is_rotate;
  reg is_lit_sub;
  reg is_file_sub;
  reg is_borrow_sub;
  reg is_swap;
  reg is_sleep;
  reg is_sub;
  reg is_file_op;
  reg alu_op;
  wire take_alu;
  wire take_sleep;

  // Subtractor operands and the per-bit borrow chain.
  reg [7:0] minuend;
  reg [7:0] subtrahend;
  reg borrow_in;
  wire [8:0] borrow_chain;
  wire [7:0] diff;
  wire half_borrow_out;
  wire borrow_out;

  // Result selection and write steering.
  reg [7:0] result;
  reg to_acc;
  reg to_file;

  // Next values of the architectural registers.
  reg [7:0] acc_d;
  reg carry_flag_d;
  reg half_borrow_flag_d;
  reg zero_flag_d;
  reg expiry_flag_d;
  reg sleep_entered_flag_d;
  reg file_we_d;
  reg [6:0] file_waddr_d;
  reg [7:0] file_wdata_d;

  // Watchdog divider: the prescaler wrap is a one-cycle enable for the counter.
  reg [PS_WIDTH-1:0] prescaler_d;
  reg [WD_WIDTH-1:0] watchdog_counter_d;
  wire wd_tick;

  genvar bit_idx;

  always @* begin
    is_rotate = 1'b0;
    is_lit_sub = 1'b0;
    is_file_sub = 1'b0;
    is_borrow_sub = 1'b0;
    is_swap = 1'b0;
    is_sleep = 1'b0;
    case (op_code)
      `OP_ROTATE_RIGHT: begin
        is_rotate = 1'b1;
      end
      `OP_LITERAL_MINUS_ACC: begin
        is_lit_sub = 1'b1;
      end
      `OP_FILE_MINUS_ACC: begin
        is_file_sub = 1'b1;
      end
      `OP_FILE_MINUS_ACC_BORROW: begin
        is_borrow_sub = 1'b1;
      end
      `OP_NIBBLE_EXCHANGE: begin
        is_swap = 1'b1;
      end
      `OP_SLEEP: begin
        is_sleep = 1'b1;
      end
      default: begin
        is_sleep = 1'b0;
      end
    endcase
    is_sub = is_lit_sub | is_file_sub | is_borrow_sub;
    is_file_op = is_rotate | is_file_sub | is_borrow_sub | is_swap;
    alu_op = is_sub | is_file_op;
  end

  // Codes 0 and 7 take neither path and leave the accumulator, flags and write address and data alone; the watchdog divider still counts.
  assign take_alu = op_valid & alu_op;
  assign take_sleep = op_valid & is_sleep;

  always @* begin
    minuend = file_data;
    subtrahend = acc_q;
    borrow_in = 1'b0;
    if (is_lit_sub) begin
      minuend = literal;
    end
    if (is_borrow_sub) begin
      // The file register stays the minuend: file minus accumulator minus borrow.
      borrow_in = ~carry_flag_q;
    end
  end

  // Full subtractor per bit; a borrow out of bit 3 or bit 7 clears the matching flag.
  assign borrow_chain[0] = borrow_in;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_sub_bit
      assign diff[bit_idx] = minuend[bit_idx] ^ subtrahend[bit_idx] ^ borrow_chain[bit_idx];
      assign borrow_chain[bit_idx + 1] = (~minuend[bit_idx] & subtrahend[bit_idx]) |
        (~(minuend[bit_idx] ^ subtrahend[bit_idx]) & borrow_chain[bit_idx]);
    end
  endgenerate
  assign half_borrow_out = borrow_chain[`HALF_BORROW_TAP];
  assign borrow_out = borrow_chain[`CARRY_TAP];

  always @* begin
    result = file_data;
    case (op_code)
      `OP_ROTATE_RIGHT: begin
        result = {carry_flag_q, file_data[7:1]};
      end
      `OP_LITERAL_MINUS_ACC: begin
        result = diff;
      end
      `OP_FILE_MINUS_ACC: begin
        result = diff;
      end
      `OP_FILE_MINUS_ACC_BORROW: begin
        result = diff;
      end
      `OP_NIBBLE_EXCHANGE: begin
        result = {file_data[3:0], file_data[7:4]};
      end
      default: begin
        result = file_data;
      end
    endcase
  end

  // The literal subtract has no file operand, so it always lands in the accumulator.
  always @* begin
    to_acc = 1'b0;
    to_file = 1'b0;
    if (take_alu) begin
      if (!is_file_op) begin
        to_acc = 1'b1;
      end else if (dest_sel == `DEST_ACC) begin
        to_acc = 1'b1;
      end else begin
        to_file = 1'b1;
      end
    end
  end

  always @* begin
    acc_d = acc_q;
    if (to_acc) begin
      acc_d = result;
    end
  end

  // The write port holds its last address and data between writes.
  always @* begin
    file_we_d = to_file;
    file_waddr_d = file_waddr_q;
    file_wdata_d = file_wdata_q;
    if (to_file) begin
      file_waddr_d = file_addr;
      file_wdata_d = result;
    end
  end

  // Rotate touches only the carry; nibble exchange touches no flag at all.
  always @* begin
    carry_flag_d = carry_flag_q;
    half_borrow_flag_d = half_borrow_flag_q;
    zero_flag_d = zero_flag_q;
    if (take_alu && is_rotate) begin
      carry_flag_d = file_data[0];
    end
    if (take_alu && is_sub) begin
      carry_flag_d = ~borrow_out;
      half_borrow_flag_d = ~half_borrow_out;
      zero_flag_d = (diff == 8'h00);
    end
  end

  always @* begin
    expiry_flag_d = expiry_flag_q;
    sleep_entered_flag_d = sleep_entered_flag_q;
    if (take_sleep) begin
      sleep_entered_flag_d = 1'b0;
      expiry_flag_d = 1'b1;
    end
  end

  assign wd_tick = &prescaler_q;

  // Low-power entry outranks a clear request arriving in the same cycle.
  always @* begin
    prescaler_d = prescaler_q + {{(PS_WIDTH-1){1'b0}}, 1'b1};
    watchdog_counter_d = watchdog_counter_q;
    if (wd_tick) begin
      watchdog_counter_d = watchdog_counter_q + {{(WD_WIDTH-1){1'b0}}, 1'b1};
    end
    if (take_sleep) begin
      prescaler_d = {PS_WIDTH{1'b0}};
      watchdog_counter_d = {WD_WIDTH{1'b0}};
    end else if (wd_clear) begin
      prescaler_d = {PS_WIDTH{1'b0}};
      watchdog_counter_d = {WD_WIDTH{1'b0}};
    end
  end

  // State registers, each with its own asynchronous reset to a constant.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= `ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carry_flag_q <= `FLAG_RESET;
    end else begin
      carry_flag_q <= carry_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_borrow_flag_q <= `FLAG_RESET;
    end else begin
      half_borrow_flag_q <= half_borrow_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zero_flag_q <= `FLAG_RESET;
    end else begin
      zero_flag_q <= zero_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      expiry_flag_q <= `EXPIRY_RESET;
    end else begin
      expiry_flag_q <= expiry_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_entered_flag_q <= `SLEEP_ENTERED_RESET;
    end else begin
      sleep_entered_flag_q <= sleep_entered_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      file_we_q <= 1'b0;
    end else begin
      file_we_q <= file_we_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      file_waddr_q <= `FILE_ADDR_RESET;
      file_wdata_q <= `FILE_DATA_RESET;
    end else begin
      file_waddr_q <= file_waddr_d;
      file_wdata_q <= file_wdata_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prescaler_q <= {PS_WIDTH{1'b0}};
      watchdog_counter_q <= {WD_WIDTH{1'b0}};
    end else begin
      prescaler_q <= prescaler_d;
      watchdog_counter_q <= watchdog_counter_d;
    end
  end

endmodule

// >>> tb/alu_ops_sva.sv
`timescale 1ns/1ps
module alu_ops_sva #(parameter WD_WIDTH = 16, parameter PS_WIDTH = 8) (
  input wire clk, input wire resetn, input wire op_valid, input wire [2:0] op_code, input wire dest_sel,
  input wire [6:0] file_addr, input wire [7:0] file_data, input wire [7:0] literal, input wire [7:0] acc_q,
  input wire carry_flag_q, input wire half_borrow_flag_q, input wire zero_flag_q, input wire expiry_flag_q,
  input wire sleep_entered_flag_q, input wire file_we_q, input wire [6:0] file_waddr_q,
  input wire [7:0] file_wdata_q, input wire [WD_WIDTH-1:0] watchdog_counter_q, input wire [PS_WIDTH-1:0] prescaler_q);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sleep_flags: assert property (op_valid && op_code == 3'h6 |=> !sleep_entered_flag_q && expiry_flag_q)
    else $error("sleep flags");
  a_sleep_wd: assert property (op_valid && op_code == 3'h6 |=> watchdog_counter_q == 0 && prescaler_q == 0)
    else $error("watchdog not cleared");
  a_rot_acc: assert property (op_valid && op_code == 3'h1 && !dest_sel |=>
    acc_q == {$past(carry_flag_q), $past(file_data[7:1])} && carry_flag_q == $past(file_data[0])) else $error("rotate");
  a_swap_file: assert property (op_valid && op_code == 3'h5 && dest_sel |=> file_we_q &&
    file_wdata_q == {$past(file_data[3:0]), $past(file_data[7:4])} && $stable(carry_flag_q) && $stable(zero_flag_q)
    && $stable(half_borrow_flag_q)) else $error("swap");
  a_dest_file: assert property (op_valid && op_code == 3'h3 && dest_sel |=>
    file_we_q && file_waddr_q == $past(file_addr) && $stable(acc_q)) else $error("destination");
  a_file_sub: assert property (op_valid && op_code == 3'h3 && !dest_sel |=>
    acc_q == $past(file_data) - $past(acc_q) && !file_we_q) else $error("file subtract result");
  a_lit_half: assert property (op_valid && op_code == 3'h2 |=>
    half_borrow_flag_q == ($past(acc_q[3:0]) <= $past(literal[3:0])) && !file_we_q) else $error("literal half borrow");
  a_idle_hold: assert property ((!op_valid || op_code == 3'h0 || op_code == 3'h7) |=>
    $stable(acc_q) && !file_we_q) else $error("idle cycle changed state");
  a_lit_sub: assert property (op_valid && op_code == 3'h2 |=> acc_q == $past(literal) - $past(acc_q) &&
    carry_flag_q == ($past(acc_q) <= $past(literal))) else $error("literal subtract");
  a_file_flags: assert property (op_valid && op_code == 3'h3 |=> carry_flag_q == ($past(acc_q) <= $past(file_data))
    && half_borrow_flag_q == ($past(acc_q[3:0]) <= $past(file_data[3:0]))) else $error("file subtract flags");
  a_borrow_sub: assert property (op_valid && op_code == 3'h4 && dest_sel |=>
    file_wdata_q == $past(file_data) - $past(acc_q) - !$past(carry_flag_q)) else $error("borrow subtract");
  a_zero_flag: assert property (op_valid && op_code inside {3'h2, 3'h3, 3'h4} && !dest_sel |=>
    zero_flag_q == (acc_q == 8'h00)) else $error("zero flag");
  c_sleep: cover property (op_valid && op_code == 3'h6);
  c_borrow: cover property (op_valid && op_code == 3'h4 && !carry_flag_q);
  c_rot: cover property (op_valid && op_code == 3'h1);
  c_swap_file: cover property (op_valid && op_code == 3'h5 && dest_sel);
endmodule
bind alu_ops alu_ops_sva #(.WD_WIDTH(WD_WIDTH), .PS_WIDTH(PS_WIDTH)) u_sva (
  .clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code), .dest_sel(dest_sel), .file_addr(file_addr),
  .file_data(file_data), .literal(literal), .acc_q(acc_q), .carry_flag_q(carry_flag_q),
  .half_borrow_flag_q(half_borrow_flag_q), .zero_flag_q(zero_flag_q), .expiry_flag_q(expiry_flag_q),
  .sleep_entered_flag_q(sleep_entered_flag_q), .file_we_q(file_we_q), .file_waddr_q(file_waddr_q),
  .file_wdata_q(file_wdata_q), .watchdog_counter_q(watchdog_counter_q), .prescaler_q(prescaler_q));

// >>> tb/alu_ops_tb_top.sv
`timescale 1ns/1ps
module alu_ops_tb_top;
  reg clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, dest_sel = 1'b0, wd_clear = 1'b0;
  reg [2:0] op_code = 3'h0;
  reg [6:0] file_addr = 7'h00;
  reg [7:0] file_data = 8'h00, literal = 8'h00;
  wire [7:0] acc_q, file_wdata_q, prescaler_q;
  wire [6:0] file_waddr_q;
  wire [15:0] watchdog_counter_q;
  wire carry_flag_q, half_borrow_flag_q, zero_flag_q, expiry_flag_q, sleep_entered_flag_q, file_we_q;
  integer n_errors = 0, check_count = 0;
  always #5 clk = ~clk;
  alu_ops dut (
    .clk(clk),
    .resetn(resetn),
    .op_valid(op_valid),
    .op_code(op_code),
    .dest_sel(dest_sel),
    .file_addr(file_addr),
    .file_data(file_data),
    .literal(literal),
    .wd_clear(wd_clear),
    .acc_q(acc_q),
    .carry_flag_q(carry_flag_q),
    .half_borrow_flag_q(half_borrow_flag_q),
    .zero_flag_q(zero_flag_q),
    .expiry_flag_q(expiry_flag_q),
    .sleep_entered_flag_q(sleep_entered_flag_q),
    .file_we_q(file_we_q),
    .file_waddr_q(file_waddr_q),
    .file_wdata_q(file_wdata_q),
    .watchdog_counter_q(watchdog_counter_q),
    .prescaler_q(prescaler_q)
  );
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task run(input [2:0] op, input d, input [7:0] fd, input [7:0] lit);
    begin
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      dest_sel <= d;
      file_data <= fd;
      file_addr <= fd[6:0];
      literal <= lit;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
    end
  endtask
  task t_sub;
    begin
      run(3'h2, 1'b0, 8'h00, 8'h21);
      chk({acc_q, carry_flag_q}, {8'h21, 1'b1});
      run(3'h4, 1'b1, 8'h13, 8'h00);
      chk({file_we_q, file_wdata_q, carry_flag_q, half_borrow_flag_q}, {1'b1, 8'hF2, 1'b0, 1'b1});
      run(3'h4, 1'b0, 8'h13, 8'h00);
      chk({acc_q, carry_flag_q, zero_flag_q}, {8'hF1, 1'b0, 1'b0});
      run(3'h2, 1'b0, 8'h00, 8'hF0);
      chk({acc_q, carry_flag_q, half_borrow_flag_q}, {8'hFF, 1'b0, 1'b0});
      run(3'h3, 1'b0, 8'hFF, 8'h00);
      chk({acc_q, carry_flag_q, zero_flag_q, half_borrow_flag_q}, {8'h00, 3'h7});
      $display("t_sub done");
    end
  endtask
  task t_rot;
    begin
      run(3'h1, 1'b1, 8'h82, 8'h00);
      chk({file_wdata_q, carry_flag_q, acc_q, file_waddr_q}, {8'hC1, 1'b0, 8'h00, 7'h02});
      run(3'h5, 1'b0, 8'h3C, 8'h00);
      chk({acc_q, carry_flag_q, zero_flag_q, file_we_q}, {8'hC3, 3'h2});
      run(3'h1, 1'b0, 8'h55, 8'h00);
      chk({acc_q, carry_flag_q, zero_flag_q, half_borrow_flag_q, file_we_q}, {8'h2A, 4'hE});
      run(3'h5, 1'b1, 8'hA5, 8'h00);
      chk({file_we_q, file_wdata_q, file_waddr_q, acc_q, carry_flag_q}, {1'b1, 8'h5A, 7'h25, 8'h2A, 1'b1});
      $display("t_rot done");
    end
  endtask
  task t_dest;
    begin
      run(3'h7, 1'b0, 8'h99, 8'h99);
      chk({acc_q, carry_flag_q, zero_flag_q, half_borrow_flag_q, file_we_q}, {8'h2A, 4'hE});
      run(3'h3, 1'b1, 8'h30, 8'h00);
      chk({file_we_q, file_wdata_q, file_waddr_q, acc_q}, {1'b1, 8'h06, 7'h30, 8'h2A});
      chk({carry_flag_q, half_borrow_flag_q, zero_flag_q}, 3'h4);
      $display("t_dest done");
    end
  endtask
  task t_sleep;
    begin
      repeat (300) @(posedge clk);
      #1;
      chk(|watchdog_counter_q, 1'b1);
      run(3'h6, 1'b0, 8'h00, 8'h00);
      chk({sleep_entered_flag_q, expiry_flag_q, watchdog_counter_q, prescaler_q}, {2'h1, 24'h000000});
      $display("t_sleep done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_sub;
    t_rot;
    t_dest;
    t_sleep;
    report_and_stop;
  end
endmodule
